/* hdl/aec_defines.svh */
// Register offsets, reset values, scaling and timing constants for the event config bank
`ifndef AEC_DEFINES_SVH
`define AEC_DEFINES_SVH

// Register offsets
`define AEC_ADDR_PART_ID     6'h00
`define AEC_ADDR_IMPACT_THR  6'h1D
`define AEC_ADDR_X_TRIM      6'h1E
`define AEC_ADDR_Y_TRIM      6'h1F
`define AEC_ADDR_Z_TRIM      6'h20
`define AEC_ADDR_IMPACT_DUR  6'h21
`define AEC_ADDR_IMPACT_WAIT 6'h22
`define AEC_ADDR_IMPACT_SPAN 6'h23
`define AEC_ADDR_MOTION_THR  6'h24
`define AEC_ADDR_STILL_THR   6'h25
`define AEC_ADDR_STILL_TIME  6'h26
`define AEC_ADDR_MOTION_CTL  6'h27
`define AEC_ADDR_IMPACT_CTL  6'h2A
`define AEC_ADDR_ORIGIN      6'h2B
`define AEC_ADDR_RATE        6'h2C
`define AEC_ADDR_POWER       6'h2D
`define AEC_ADDR_IRQ_EN      6'h2E
`define AEC_ADDR_IRQ_ROUTE   6'h2F
`define AEC_ADDR_IRQ_CAUSE   6'h30
`define AEC_ADDR_FORMAT      6'h31
`define AEC_ADDR_X_LOW       6'h32
`define AEC_ADDR_X_HIGH      6'h33
`define AEC_ADDR_Y_LOW       6'h34
`define AEC_ADDR_Y_HIGH      6'h35
`define AEC_ADDR_Z_LOW       6'h36
`define AEC_ADDR_Z_HIGH      6'h37
`define AEC_ADDR_QUEUE_CTL   6'h38
`define AEC_ADDR_QUEUE_STAT  6'h39

// Reset values
`define AEC_RST_ZERO         8'h00
`define AEC_RST_RATE         8'h0A
`define AEC_RST_IRQ_CAUSE    8'h02

// Field positions in the control registers
`define AEC_MOTION_COUPLE_BIT 7
`define AEC_MOTION_EN_LSB     4
`define AEC_STILL_COUPLE_BIT  3
`define AEC_STILL_EN_LSB      0
`define AEC_SUPPRESS_BIT      3
`define AEC_IMPACT_EN_LSB     0

// Scaling: sample count 48.75 mg, threshold count 780 mg, trim count 0.195 g
`define AEC_THR_SHIFT  4
`define AEC_TRIM_SHIFT 2

// Time steps and their cycle counts at 20 MHz
`define AEC_CLK_PERIOD_NS   50
`define AEC_DUR_STEP_US     625
`define AEC_WAIT_STEP_US    1250
`define AEC_STILL_STEP_S    1
`define AEC_DUR_STEP_CYC    ((`AEC_DUR_STEP_US * 1000) / `AEC_CLK_PERIOD_NS)
`define AEC_WAIT_STEP_CYC   ((`AEC_WAIT_STEP_US * 1000) / `AEC_CLK_PERIOD_NS)
`define AEC_STILL_STEP_CYC  ((`AEC_STILL_STEP_S * 1000000000) / `AEC_CLK_PERIOD_NS)

`endif

/* hdl/aec_pkg.sv */
// Types shared by the accelerometer event config bank
package aec_pkg;

  // Three axes, index 2 = x, 1 = y, 0 = z
  typedef logic [2:0][15:0] aec_axes_t;

  typedef struct packed {
    logic single_impact;
    logic double_impact;
    logic motion;
    logic stillness;
  } aec_events_t;

  typedef struct packed {
    logic [7:0] rate;
    logic [7:0] power;
    logic [7:0] irq_enable;
    logic [7:0] irq_routing;
    logic [7:0] out_format;
    logic [7:0] queue_ctl;
  } aec_side_cfg_t;

  typedef enum logic [2:0] {
    IMP_IDLE, IMP_HIT1, IMP_HOLD, IMP_LAT, IMP_WIN, IMP_HIT2
  } aec_imp_state_t;

  // Writable locations of the bank
  function automatic logic aec_is_rw(input int unsigned a);
    return (a >= 29 && a <= 39) || (a >= 42 && a <= 47 && a != 43) ||
           a == 49 || a == 56;
  endfunction

endpackage

/* hdl/aec_tick_gen.sv */
// Free step timer: one-cycle tick every PERIOD clocks, restartable
`timescale 1ns/100ps
module aec_tick_gen #(
  parameter int unsigned PERIOD = 1
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Control and tick
  input  wire logic restart,
  output logic      tick
);

  logic [31:0] count;

  // Restart aligns the first tick a full step after a state change
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h00000000;
      tick  <= 1'b0;
    end else if (restart) begin
      count <= 32'h00000000;
      tick  <= 1'b0;
    end else if (count == PERIOD - 1) begin
      count <= 32'h00000000;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h00000001;
      tick  <= 1'b0;
    end
  end

endmodule

/* hdl/aec_axis_cmp.sv */
// One axis compared against a threshold, directly or against a held reference
`timescale 1ns/100ps
`include "aec_defines.svh"
module aec_axis_cmp (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Sample and settings
  input  wire logic [15:0] sample,
  input  wire logic [7:0]  threshold,
  input  wire logic        coupled,
  input  wire logic        capture,
  // Result
  output logic             above
);

  logic signed [15:0] reference;
  logic signed [16:0] diff;
  logic        [16:0] magnitude;
  logic        [16:0] limit;

  // Reference taken when the caller says the baseline moves
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      reference <= 16'sh0000;
    else if (capture)
      reference <= $signed(sample);
  end

  // Wide difference so a full-scale swing cannot wrap
  always_comb begin
    diff      = coupled ? ($signed({sample[15], sample}) - $signed({reference[15], reference}))
                        : $signed({sample[15], sample});
    magnitude = diff[16] ? 17'(-diff) : 17'(diff);
    limit     = 17'({threshold, {`AEC_THR_SHIFT{1'b0}}});
    above     = magnitude > limit;
  end

endmodule

/* hdl/aec_regs.sv */
// Event configuration register bank with impact, motion and stillness detection
`timescale 1ns/100ps
`include "aec_defines.svh"
// Contract
// - Every addressable register is eight bits wide.
// - Lowest address returns a fixed identity code; writes cannot change it.
// - Impact threshold is unsigned, 780 mg per count.
// - Signed axis trim, 0.195 g per count, added into output samples.
// - Impact qualifies only if above threshold no longer than duration limit.
// - Zero duration limit disables single and double impact detection.
// - Wait after impact, 1.25 ms steps, before span; zero disables double.
// - Second impact must start within span, 1.25 ms steps; zero disables double.
// - Motion compares magnitude against unsigned motion threshold, 780 mg/count.
// - Stillness compares magnitude against unsigned stillness threshold, 780 mg/count.
// - Stillness declared after below threshold for stillness time, one-second steps.
// - Stillness uses filtered samples; impact and motion use raw samples.
// - No stillness event before at least one output sample exists.
// - Zero stillness time flags stillness as soon as a sample is below.
// - Motion control holds couplings in D7/D3, axis enables in D6-4/D2-0.
// - Reset loads rate 0x0A, cause 0x02, everything else zero.
// - Coupling clear compares magnitude; set compares difference from reference.
// - Motion ORs enabled axes, stillness ANDs them; none enabled disables.
module aec_regs
  import aec_pkg::*;
#(
  parameter logic [7:0]  PART_ID           = 8'h5A, // arbitrary identity value
  parameter int unsigned DUR_STEP_CYCLES   = `AEC_DUR_STEP_CYC,
  parameter int unsigned WAIT_STEP_CYCLES  = `AEC_WAIT_STEP_CYC,
  parameter int unsigned STILL_STEP_CYCLES = `AEC_STILL_STEP_CYC
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  // Register port from the serial engine
  input  wire logic [5:0]    reg_addr,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [7:0]    reg_wdata,
  output logic      [7:0]    reg_rdata,
  output logic               reg_rdata_valid,
  // Sample path
  input  wire logic          raw_valid,
  input  wire aec_axes_t     raw_axes,
  input  wire logic          filt_valid,
  input  wire aec_axes_t     filt_axes,
  // Events and side configuration
  output aec_events_t        events,
  output aec_side_cfg_t      side_cfg
);

  logic [7:0]     bank [64];
  aec_axes_t      out_axes;
  logic [7:0]     origin;
  logic [2:0]     imp_above;
  logic [2:0]     mot_above;
  logic [2:0]     stl_above;
  logic [2:0]     imp_en;
  logic [2:0]     mot_en;
  logic [2:0]     stl_en;
  logic           imp_hit;
  logic           imp_hit_lvl;
  logic [2:0]     imp_axes_lvl;
  logic           mot_hit;
  logic           mot_active;
  logic           mot_armed;
  logic           mot_capture;
  logic           stl_below;
  logic           stl_ref_ok;
  logic           stl_capture;
  logic           stl_run;
  logic           stl_flag;
  logic [7:0]     stl_secs;
  logic           sec_tick;
  logic           dur_tick;
  logic           wait_tick;
  logic           imp_restart;
  aec_imp_state_t imp_state;
  logic [8:0]     imp_count;
  logic           single_p;
  logic           double_p;
  logic           motion_p;
  logic           still_p;
  logic           ctl_write;

  // Writable bank: one byte per location, read-only spots never stored
  for (genvar a = 0; a < 64; a++) begin : g_bank
    if (aec_is_rw(a)) begin : g_rw
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
          bank[a] <= (a == `AEC_ADDR_RATE) ? `AEC_RST_RATE : `AEC_RST_ZERO;
        else if (reg_wr && reg_addr == 6'(a))
          bank[a] <= reg_wdata;
      end
    end else begin : g_ro
      // Read-only and reserved spots drop writes
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
          bank[a] <= `AEC_RST_ZERO;
        else
          bank[a] <= `AEC_RST_ZERO;
      end
    end
  end

  // Field unpacking of the control registers
  assign mot_en    = bank[`AEC_ADDR_MOTION_CTL][`AEC_MOTION_EN_LSB +: 3];
  assign stl_en    = bank[`AEC_ADDR_MOTION_CTL][`AEC_STILL_EN_LSB +: 3];
  assign imp_en    = bank[`AEC_ADDR_IMPACT_CTL][`AEC_IMPACT_EN_LSB +: 3];
  assign ctl_write = reg_wr && reg_addr == `AEC_ADDR_MOTION_CTL;

  // Per-axis comparators and trimmed output samples
  for (genvar i = 0; i < 3; i++) begin : g_axis
    aec_axis_cmp u_imp (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .sample    (raw_axes[i]),
      .threshold (bank[`AEC_ADDR_IMPACT_THR]),
      .coupled   (1'b0),
      .capture   (1'b0),
      .above     (imp_above[i])
    );
    aec_axis_cmp u_mot (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .sample    (raw_axes[i]),
      .threshold (bank[`AEC_ADDR_MOTION_THR]),
      .coupled   (bank[`AEC_ADDR_MOTION_CTL][`AEC_MOTION_COUPLE_BIT]),
      .capture   (mot_capture),
      .above     (mot_above[i])
    );
    aec_axis_cmp u_stl (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .sample    (filt_axes[i]),
      .threshold (bank[`AEC_ADDR_STILL_THR]),
      .coupled   (bank[`AEC_ADDR_MOTION_CTL][`AEC_STILL_COUPLE_BIT]),
      .capture   (stl_capture),
      .above     (stl_above[i])
    );

    // Sample plus scaled trim; wraps at 16 bits like the raw path
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
        out_axes[i] <= 16'h0000;
      else if (raw_valid)
        out_axes[i] <= raw_axes[i] + (16'($signed(bank[`AEC_ADDR_Z_TRIM - 6'(i)])) <<<
                                          `AEC_TRIM_SHIFT);
    end
  end

  // Axis combination
  assign imp_hit   = |(imp_above & imp_en);
  assign mot_hit   = |(mot_above & mot_en);
  assign stl_below = (stl_en != 3'b000) && ((stl_above & stl_en) == 3'b000);

  // Motion: reference taken on the sample that arms, the first one after a control write
  assign mot_capture = raw_valid && !mot_armed;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mot_armed  <= 1'b0;
      mot_active <= 1'b0;
      motion_p   <= 1'b0;
    end else begin
      motion_p <= 1'b0;
      if (ctl_write) begin
        // New settings invalidate the held baseline
        mot_armed  <= 1'b0;
        mot_active <= 1'b0;
      end else if (raw_valid) begin
        mot_armed  <= 1'b1;
        mot_active <= mot_armed && mot_hit;
        if (mot_armed && mot_hit && !mot_active && mot_en != 3'b000)
          motion_p <= 1'b1;
      end
    end
  end

  // Stillness baseline follows the signal whenever it exceeds the threshold
  assign stl_capture = filt_valid && (!stl_ref_ok || !stl_below);
  aec_tick_gen #(
    .PERIOD (STILL_STEP_CYCLES)
  ) u_sec (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .restart (!stl_run),
    .tick    (sec_tick)
  );

  // Stillness timer and single-shot event per quiet period
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stl_ref_ok <= 1'b0;
      stl_run    <= 1'b0;
      stl_secs   <= 8'h00;
      stl_flag   <= 1'b0;
      still_p    <= 1'b0;
    end else begin
      still_p <= 1'b0;
      if (ctl_write) begin
        stl_ref_ok <= 1'b0;
        stl_run    <= 1'b0;
        stl_secs   <= 8'h00;
        stl_flag   <= 1'b0;
      end else begin
        if (sec_tick && stl_run && stl_secs != 8'hFF)
          stl_secs <= stl_secs + 8'h01;
        // Only a produced sample can declare stillness
        if (filt_valid) begin
          stl_ref_ok <= 1'b1;
          if (!stl_below) begin
            stl_run  <= 1'b0;
            stl_secs <= 8'h00;
            stl_flag <= 1'b0;
          end else begin
            stl_run <= 1'b1;
            if (!stl_flag && stl_secs >= bank[`AEC_ADDR_STILL_TIME]) begin
              still_p  <= 1'b1;
              stl_flag <= 1'b1;
            end
          end
        end
      end
    end
  end

  // Impact level sampled per raw sample so timers see a steady hit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      imp_hit_lvl  <= 1'b0;
      imp_axes_lvl <= 3'b000;
    end else if (raw_valid) begin
      imp_hit_lvl  <= imp_hit;
      imp_axes_lvl <= imp_hit ? (imp_above & imp_en) : imp_axes_lvl; // Last hit axes
    end
  end

  aec_tick_gen #(
    .PERIOD (DUR_STEP_CYCLES)
  ) u_dur (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .restart (imp_restart),
    .tick    (dur_tick)
  );

  aec_tick_gen #(
    .PERIOD (WAIT_STEP_CYCLES)
  ) u_wait (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .restart (imp_restart),
    .tick    (wait_tick)
  );

  // Impact sequencer: first hit, wait, span, second hit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      imp_state   <= IMP_IDLE;
      imp_count   <= 9'h000;
      imp_restart <= 1'b0;
      single_p    <= 1'b0;
      double_p    <= 1'b0;
    end else begin
      imp_restart <= 1'b0;
      single_p    <= 1'b0;
      double_p    <= 1'b0;
      case (imp_state)
        IMP_IDLE: begin
          if (imp_hit_lvl && bank[`AEC_ADDR_IMPACT_DUR] != 8'h00) begin
            imp_state   <= IMP_HIT1;
            imp_count   <= 9'h000;
            imp_restart <= 1'b1;
          end
        end
        IMP_HIT1, IMP_HIT2: begin
          if (!imp_hit_lvl) begin
            imp_count   <= 9'h000;
            imp_restart <= 1'b1;
            if (imp_state == IMP_HIT2) begin
              double_p  <= 1'b1;
              imp_state <= IMP_IDLE;
            end else begin
              single_p <= 1'b1;
              // Either timing field at zero turns off the second impact
              if (bank[`AEC_ADDR_IMPACT_WAIT] != 8'h00 &&
                  bank[`AEC_ADDR_IMPACT_SPAN] != 8'h00)
                imp_state <= IMP_LAT;
              else
                imp_state <= IMP_IDLE;
            end
          end else if (dur_tick) begin
            imp_count <= imp_count + 9'h001;
            if (imp_count + 9'h001 > {1'b0, bank[`AEC_ADDR_IMPACT_DUR]})
              imp_state <= IMP_HOLD;
          end
        end
        IMP_HOLD: begin
          // Too long a hit: wait for release without reporting
          if (!imp_hit_lvl)
            imp_state <= IMP_IDLE;
        end
        IMP_LAT: begin
          if (bank[`AEC_ADDR_IMPACT_CTL][`AEC_SUPPRESS_BIT] && imp_hit_lvl)
            imp_state <= IMP_IDLE;
          else if (wait_tick) begin
            imp_count <= imp_count + 9'h001;
            if (imp_count + 9'h001 >= {1'b0, bank[`AEC_ADDR_IMPACT_WAIT]}) begin
              imp_state   <= IMP_WIN;
              imp_count   <= 9'h000;
              imp_restart <= 1'b1;
            end
          end
        end
        IMP_WIN: begin
          if (imp_hit_lvl) begin
            imp_state   <= IMP_HIT2;
            imp_count   <= 9'h000;
            imp_restart <= 1'b1;
          end else if (wait_tick) begin
            imp_count <= imp_count + 9'h001;
            if (imp_count + 9'h001 >= {1'b0, bank[`AEC_ADDR_IMPACT_SPAN]})
              imp_state <= IMP_IDLE;
          end
        end
        default: imp_state <= IMP_IDLE;
      endcase
    end
  end

  // Axes of the latest motion event and of the last hit sample before the latest single impact
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      origin <= `AEC_RST_ZERO;
    else begin
      if (mot_fire())
        origin[6:4] <= mot_above & mot_en;
      if (single_p)
        origin[2:0] <= imp_axes_lvl;
    end
  end

  function automatic logic mot_fire();
    return !ctl_write && raw_valid && mot_armed && mot_hit && !mot_active && mot_en != 3'b000;
  endfunction

  // Registered read answer; reserved and unmapped read as zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata       <= 8'h00;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `AEC_ADDR_PART_ID:    reg_rdata <= PART_ID;
          `AEC_ADDR_ORIGIN:     reg_rdata <= origin;
          `AEC_ADDR_IRQ_CAUSE:  reg_rdata <= `AEC_RST_IRQ_CAUSE;
          `AEC_ADDR_X_LOW:      reg_rdata <= out_axes[2][7:0];
          `AEC_ADDR_X_HIGH:     reg_rdata <= out_axes[2][15:8];
          `AEC_ADDR_Y_LOW:      reg_rdata <= out_axes[1][7:0];
          `AEC_ADDR_Y_HIGH:     reg_rdata <= out_axes[1][15:8];
          `AEC_ADDR_Z_LOW:      reg_rdata <= out_axes[0][7:0];
          `AEC_ADDR_Z_HIGH:     reg_rdata <= out_axes[0][15:8];
          `AEC_ADDR_QUEUE_STAT: reg_rdata <= 8'h00;
          default:              reg_rdata <= bank[reg_addr];
        endcase
      end
    end
  end

  // Outputs, all straight from flops
  assign events   = '{single_impact: single_p, double_impact: double_p,
                      motion: motion_p, stillness: still_p};
  assign side_cfg = '{rate: bank[`AEC_ADDR_RATE], power: bank[`AEC_ADDR_POWER],
                      irq_enable: bank[`AEC_ADDR_IRQ_EN],
                      irq_routing: bank[`AEC_ADDR_IRQ_ROUTE],
                      out_format: bank[`AEC_ADDR_FORMAT],
                      queue_ctl: bank[`AEC_ADDR_QUEUE_CTL]};

endmodule

/* verification/aec_regs_monitor.sv */
// Port checker for the event config bank
`timescale 1ns/100ps
module aec_regs_monitor
  import aec_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5A
) (
  // Clock and reset
  input wire logic          ref_clk,
  input wire logic          rst_n,
  // Bus
  input wire logic [5:0]    reg_addr,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [7:0]    reg_wdata,
  input wire logic [7:0]    reg_rdata,
  input wire logic          reg_rdata_valid,
  // Data
  input wire logic          raw_valid,
  input wire aec_axes_t     raw_axes,
  input wire logic          filt_valid,
  input wire aec_axes_t     filt_axes,
  input wire aec_events_t   events,
  input wire aec_side_cfg_t side_cfg
);
  // One domain, so clock and reset given once
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  chk_read_answer:
    assert property (reg_rd |=> reg_rdata_valid) else $error("no answer");
  chk_no_stray:
    assert property (!reg_rd |=> !reg_rdata_valid) else $error("stray answer");
  chk_part_id:
    assert property (reg_rd && reg_addr == 6'h00 |=> reg_rdata == PART_ID) else $error("id");
  chk_cause_fixed:
    assert property (reg_rd && reg_addr == 6'h30 |=> reg_rdata == 8'h02) else $error("cause");
  chk_rate_write:
    assert property (reg_wr && reg_addr == 6'h2C |=> side_cfg.rate == $past(reg_wdata))
      else $error("rate");
  chk_cfg_hold:
    assert property (!reg_wr |=> $stable(side_cfg)) else $error("config moved");
  chk_motion_raw:
    assert property (events.motion |-> $past(raw_valid)) else $error("motion cause");
  chk_still_filt:
    assert property (events.stillness |-> $past(filt_valid)) else $error("still cause");
endmodule

bind aec_regs aec_regs_monitor #(.PART_ID(PART_ID)) u_aec_regs_monitor (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rdata_valid(reg_rdata_valid), .raw_valid(raw_valid), .raw_axes(raw_axes),
  .filt_valid(filt_valid), .filt_axes(filt_axes), .events(events), .side_cfg(side_cfg)
);

/* verification/aec_host_model.sv */
// Host model driving the register port a byte at a time
`timescale 1ns/100ps
module aec_host_model (
  // Clock
  input  wire logic       ref_clk,
  // Bus
  output logic      [5:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rdata_valid
);
  // Idle port from time zero
  initial begin
    reg_addr = 6'h3F;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // Write; callers also use it on reserved and read-only spots
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a; // Released lines show stale-free values
    reg_wdata <= ~v;
    @(posedge ref_clk);
  endtask

  // Read; answer taken at the edge after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge ref_clk);
    v = reg_rdata_valid === 1'b1 ? reg_rdata : 8'hXX;
  endtask
endmodule

/* verification/tb_aec_regs.sv */
// Self-checking bench for the event config bank
`timescale 1ns/100ps
module tb_aec_regs
  import aec_pkg::*;
;
  localparam logic [7:0]  ID = 8'h5A; // Arbitrary identity value
  localparam aec_axes_t   HIT = 48'h0100_0000_0000;
  localparam aec_axes_t   BIG = 48'h0100_0100_0100;
  // Motion: control, axis, base, value, pulses
  localparam logic [7:0]  MC [8] = '{8'h00, 8'h40, 8'h20, 8'h20, 8'h10, 8'h40, 8'hC0, 8'hC0};
  localparam int          MA [8] = '{2, 2, 2, 1, 0, 2, 2, 2};
  localparam logic [15:0] MB [8] = '{0, 0, 0, 0, 0, 0, 16'h28, 16'h28};
  localparam logic [15:0] MV [8] = '{16'h28, 16'h28, 16'h28, 16'h28, 16'h28, 16'hFFD8, 16'h28,
                                     16'h50};
  localparam int          ME [8] = '{0, 1, 0, 1, 1, 1, 0, 1};
  // Impact: duration, wait, span, hold, pulses
  localparam logic [7:0]  ID_ [6] = '{8'h00, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
  localparam logic [7:0]  IW [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01};
  localparam logic [7:0]  IS [6] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h00};
  localparam int          IH [6] = '{0, 0, 30, 0, 0, 0};
  localparam int          ES [6] = '{0, 1, 0, 0, 0, 0};
  localparam int          ED [6] = '{0, 0, 0, 1, 0, 0};
  // Ports and tallies
  logic          ref_clk = 1'b0;
  logic          rst_n = 1'b0;
  logic [5:0]    reg_addr;
  logic          reg_wr;
  logic          reg_rd;
  logic [7:0]    reg_wdata;
  logic [7:0]    reg_rdata;
  logic          reg_rdata_valid;
  logic          raw_valid = 1'b0;
  logic          filt_valid = 1'b0;
  aec_axes_t     raw_axes = '0;
  aec_axes_t     filt_axes = '0;
  aec_events_t   events;
  aec_side_cfg_t side_cfg;
  int unsigned   n_fail = 0;
  int unsigned   total_checks = 0;
  int unsigned   ev_cnt [4] = '{default: 0};
  logic [7:0]    mem [64];

  always #25 ref_clk = ~ref_clk;
  aec_host_model u_aec_host_model (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid)
  );
  // Short time steps keep the run brief
  aec_regs #(
    .PART_ID(ID), .DUR_STEP_CYCLES(4), .WAIT_STEP_CYCLES(8), .STILL_STEP_CYCLES(16)
  ) u_aec_regs (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .raw_valid(raw_valid), .raw_axes(raw_axes),
    .filt_valid(filt_valid), .filt_axes(filt_axes), .events(events), .side_cfg(side_cfg)
  );

  // Pulse tally by non-blocking update, so reads at an edge are stable
  always @(posedge ref_clk) begin
    for (int k = 0; k < 4; k++) ev_cnt[k] <= ev_cnt[k] + 32'(events[k] === 1'b1);
  end

  function automatic logic [7:0] rst_val(input logic [5:0] a);
    return a == 6'h00 ? ID : a == 6'h2C ? 8'h0A : a == 6'h30 ? 8'h02 : 8'h00;
  endfunction
  function automatic logic is_rw(input logic [5:0] a);
    return (a >= 6'h1D && a <= 6'h27) || a == 6'h2A || (a >= 6'h2C && a <= 6'h2F)
      || a == 6'h31 || a == 6'h38;
  endfunction
  function automatic aec_axes_t ax(input int i, input logic [15:0] v);
    aec_axes_t r;
    r = '0;
    r[i] = v;
    return r;
  endfunction

  task automatic gap(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_aec_host_model.rd(a, v);
    chk({8'h00, v}, {8'h00, e});
  endtask
  task automatic w(input logic [5:0] a, input logic [7:0] v);
    u_aec_host_model.wr(a, v);
  endtask
  task automatic evchk(input int k, input int unsigned b, input int e);
    chk(16'(ev_cnt[k] - b), 16'(e));
  endtask
  // One strobe, then an idle cycle
  task automatic samp(input aec_axes_t v, input logic f);
    raw_axes <= v;
    filt_axes <= v;
    raw_valid <= !f;
    filt_valid <= f;
    @(posedge ref_clk);
    raw_valid <= 1'b0;
    filt_valid <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    logic [15:0] s;
    aec_axes_t   r;
    int unsigned b;
    int unsigned b2;
    void'($urandom(32'h3B23AFD5));
    gap(6);
    rst_n <= 1'b1;
    gap(1);
    // Reset image, unmapped 0x28, 0x29 and 0x3A included
    for (int a = 0; a < 59; a++) begin
      mem[a] = rst_val(6'(a));
      if (a == 0 || a > 28) rchk(6'(a), mem[a]);
    end
    $display("test reset done");
    // Random bytes at 0x00 and 0x1D-0x3A; read-only places keep their value
    for (int a = 0; a < 59; a++) begin
      s = 16'($urandom);
      if (a == 0 || a > 28) w(6'(a), s[7:0]);
      if (is_rw(6'(a))) mem[a] = s[7:0];
    end
    for (int a = 0; a < 59; a++) begin
      if (a == 0 || a > 28) rchk(6'(a), mem[a]);
    end
    $display("test access done");
    // One raw sample through the random trims, low byte first
    r = {16'($signed(14'($urandom))), 16'($signed(14'($urandom))), 16'($signed(14'($urandom)))};
    samp(r, 1'b0);
    for (int i = 0; i < 3; i++) begin
      s = r[2 - i] + {{6{mem[30 + i][7]}}, mem[30 + i], 2'b00};
      rchk(6'(50 + 2 * i), s[7:0]);
      rchk(6'(51 + 2 * i), s[15:8]);
    end
    for (int a = 29; a < 57; a++) begin
      if (is_rw(6'(a))) w(6'(a), 8'h00);
    end
    $display("test trim done");
    // Motion over 32 sample counts; first sample after a control write is baseline
    w(6'h24, 8'h02);
    for (int i = 0; i < 8; i++) begin
      w(6'h27, MC[i]);
      samp(ax(MA[i], MB[i]), 1'b0);
      b = ev_cnt[1];
      samp(ax(MA[i], MB[i]), 1'b0);
      samp(ax(MA[i], MV[i]), 1'b0);
      gap(2);
      evchk(1, b, ME[i]);
    end
    $display("test motion done");
    // Stillness on filtered samples only, none before the first one
    w(6'h25, 8'h02);
    w(6'h27, 8'h07);
    b = ev_cnt[0];
    gap(20);
    evchk(0, b, 0);
    for (int i = 0; i < 4; i++) begin
      w(6'h27, i == 3 ? 8'h00 : i == 2 ? 8'h03 : 8'h07);
      samp(BIG, 1'b1);
      b = ev_cnt[0];
      samp(ax(2, i % 3 == 0 ? 16'h0000 : 16'h0028), 1'b1);
      gap(2);
      evchk(0, b, i % 2 == 0 ? 1 : 0);
    end
    w(6'h26, 8'h01);
    w(6'h27, 8'h07);
    samp(BIG, 1'b1);
    b = ev_cnt[0];
    samp(48'h0, 1'b1);
    gap(2);
    evchk(0, b, 0);
    repeat (20) samp(48'h0, 1'b1);
    gap(2);
    evchk(0, b, 1);
    $display("test stillness done");
    // Impact on x; double cases hit twice; both set origin x bits
    w(6'h1D, 8'h01);
    w(6'h2A, 8'h04);
    for (int i = 0; i < 6; i++) begin
      w(6'h21, ID_[i]);
      w(6'h22, IW[i]);
      w(6'h23, IS[i]);
      b = ev_cnt[3];
      b2 = ev_cnt[2];
      samp(HIT, 1'b0);
      gap(IH[i]);
      samp(48'h0, 1'b0);
      if (i > 2) begin
        gap(14);
        samp(HIT, 1'b0);
        samp(48'h0, 1'b0);
      end
      gap(60);
      if (i < 3) evchk(3, b, ES[i]);
      evchk(2, b2, ED[i]);
    end
    rchk(6'h2B, 8'h44);
    $display("test impact done");
    test_done();
  end

  // Run needs about a thousand cycles; a hang ends here
  initial begin
    #(40000 * 50);
    n_fail++;
    test_done();
  end
endmodule
